// ---- rtl/uttb_pkg.sv ----
// Package: register map, bit fields, timing counts and state types of the line logic
package uttb_pkg;

   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_TXHOLD = 8'h0C;
   localparam logic [7:0] OFF_RXIDLE = 8'h10;
   localparam logic [7:0] OFF_GUARD = 8'h14;
   localparam logic [7:0] OFF_BAUD = 8'h18;

   // Command bits of control_cmd_reg
   localparam int CMD_CLR = 0;
   localparam int CMD_BRK_START = 1;
   localparam int CMD_BRK_STOP = 2;
   localparam int CMD_ARM = 3;
   localparam int CMD_RELOAD = 4;

   // Mode register bits
   localparam int MODE_SYNC = 0;
   localparam int MODE_PAR = 1;

   // Bits of channel_status_reg
   localparam int ST_TXFREE = 0;
   localparam int ST_TXIDLE = 1;
   localparam int ST_RXBREAK = 2;
   localparam int ST_FRAME = 3;
   localparam int ST_TIMEOUT = 4;

   // Reset values
   localparam logic [15:0] BAUD_RST = 16'h0014;
   localparam logic [15:0] RXIDLE_RST = 16'h0000;
   localparam logic [7:0] GUARD_RST = 8'h00;

   // Timing counts, in samples or bit periods
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [1:0] BRK_END_ASYNC = 2'h2;
   localparam logic [1:0] BRK_END_SYNC = 2'h1;
   localparam logic [7:0] BRK_IDLE_MIN = 8'h0C;
   localparam logic [3:0] TX_REM_BITS = 4'h9;
   localparam logic [3:0] RX_LAST_BIT = 4'h8;

   typedef enum logic [2:0] {TX_IDLE, TX_SHIFT, TX_GUARD, TX_BREAK, TX_POSTBRK} uttb_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_BREAK} uttb_rx_e;

   typedef struct packed {
      logic [15:0] cnt;
      logic [3:0] sub;
      logic sample_tick;
      logic bit_tick;
   } uttb_baud_s;

   typedef struct packed {
      logic [31:0] rdata;
      logic txd;
      logic mode_sync;
      logic mode_par;
      logic [15:0] baud_div;
      logic [15:0] to_value;
      logic [7:0] guard;
      logic [15:0] to_cnt;
      logic to_run;
      logic to_flag;
      logic frame_flag;
      logic brk_flag;
      logic tx_free;
      logic tx_all_idle;
      logic hold_full;
      logic [7:0] tx_hold;
      logic brk_pend;
      logic brk_on;
      logic brk_stop_req;
      uttb_tx_e tx_state;
      logic [9:0] tx_shift;
      logic [3:0] tx_bits;
      logic [7:0] tx_gcnt;
      uttb_rx_e rx_state;
      logic [3:0] rx_cnt;
      logic [3:0] rx_idx;
      logic rx_zero;
      logic [1:0] rx_hcnt;
   } uttb_state_s;

endpackage

// ---- rtl/uttb_baud.sv ----
// Baud tick generator: sample ticks and bit-period ticks
`timescale 1ns/1ps
module uttb_baud (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] div,
   input wire logic sync,
   output logic sample_tick,
   output logic bit_tick
);

   uttb_pkg::uttb_baud_s s;
   uttb_pkg::uttb_baud_s n;

   // Divide the clock; sixteen samples make a bit unless in sync mode
   always_comb begin
      n = s;
      n.sample_tick = 1'b0;
      n.bit_tick = 1'b0;
      if (s.cnt >= div) begin
         n.cnt = 16'h0000;
         n.sample_tick = 1'b1;
         n.sub = s.sub + 4'h1;
         n.bit_tick = sync || (s.sub == uttb_pkg::OS_LAST);
      end else begin
         n.cnt = s.cnt + 16'h0001;
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign sample_tick = s.sample_tick;
   assign bit_tick = s.bit_tick;

endmodule

// ---- rtl/uttb_line.sv ----
// Line-condition logic: receive time-out, framing, transmit and receive break
//
// Function
// - Zero time-out value disables time-out flag
// - Nonzero value loads 16-bit counter, decrements per bit
// - Counter reaching zero raises time-out flag
// - Arm command stops counting until next character
// - Reload command restarts counter at once
// - Low stop bit flags framing error mid-bit
// - Framing flag holds until clear-status command
// - Break holds line low one full character
// - Break waits for current character to finish
// - Further break starts ignored until break ends
// - Early break stop still completes minimum break
// - Break commands taken only while holding free
// - Break stop without start is ignored
// - Holding write during pending break discarded
// - After break, line high max(12, guard)
// - All-zero character raises break, not framing
// - Break flag holds until clear-status command
// - High after break re-asserts break flag
// - Guard period inserts idle bits, zero none
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module uttb_line (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic rxd,
   output logic txd
);

   uttb_pkg::uttb_state_s s;
   uttb_pkg::uttb_state_s n;
   logic sample_tick;
   logic bit_tick;
   logic ctrl_wr;
   logic clr_cmd;
   logic brk_start_cmd;
   logic brk_stop_cmd;
   logic arm_cmd;
   logic reload_cmd;
   logic hold_wr;
   logic brk_start_ok;
   logic brk_stop_ok;
   logic brk_start_now;
   logic tx_go;
   logic rx_done;
   logic rx_brk_hit;
   logic rx_frame_hit;
   logic rx_brk_end;
   logic [3:0] rx_target;
   logic [3:0] rx_last;
   logic [1:0] brk_end_need;
   logic [7:0] post_len;
   logic [31:0] status;

   ////////////////////////////////////////////////////////////////////////
   // Baud ticks
   uttb_baud u_baud (
      .clk(clk),
      .resetn(resetn),
      .div(s.baud_div),
      .sync(s.mode_sync),
      .sample_tick(sample_tick),
      .bit_tick(bit_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command decode; a command write is a single-cycle pulse
   assign ctrl_wr = wr_en && (addr == uttb_pkg::OFF_CTRL);
   assign clr_cmd = ctrl_wr && wdata[uttb_pkg::CMD_CLR];
   assign brk_start_cmd = ctrl_wr && wdata[uttb_pkg::CMD_BRK_START];
   assign brk_stop_cmd = ctrl_wr && wdata[uttb_pkg::CMD_BRK_STOP];
   assign arm_cmd = ctrl_wr && wdata[uttb_pkg::CMD_ARM];
   assign reload_cmd = ctrl_wr && wdata[uttb_pkg::CMD_RELOAD];
   assign hold_wr = wr_en && (addr == uttb_pkg::OFF_TXHOLD);

   // Break commands only while holding is free, as for a character
   assign brk_start_ok = brk_start_cmd && s.tx_free && !s.brk_pend && !s.brk_on;
   assign brk_stop_ok = brk_stop_cmd && s.tx_free && (s.brk_pend || s.brk_on)
      && (s.tx_state != uttb_pkg::TX_POSTBRK);

   // Receiver sample spacing and end-of-break length per mode
   assign rx_target = s.mode_sync ? 4'h0 :
      ((s.rx_state == uttb_pkg::RX_START) ? uttb_pkg::OS_MID : uttb_pkg::OS_LAST);
   assign rx_last = uttb_pkg::RX_LAST_BIT + {3'h0, s.mode_par};
   assign brk_end_need = s.mode_sync ? uttb_pkg::BRK_END_SYNC : uttb_pkg::BRK_END_ASYNC;
   // Idle after break is the longer of the fixed minimum and the guard
   assign post_len = (s.guard > uttb_pkg::BRK_IDLE_MIN) ? s.guard : uttb_pkg::BRK_IDLE_MIN;

   // Status word
   always_comb begin
      status = 32'h0000_0000;
      status[uttb_pkg::ST_TXFREE] = s.tx_free;
      status[uttb_pkg::ST_TXIDLE] = s.tx_all_idle;
      status[uttb_pkg::ST_RXBREAK] = s.brk_flag;
      status[uttb_pkg::ST_FRAME] = s.frame_flag;
      status[uttb_pkg::ST_TIMEOUT] = s.to_flag;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      n = s;
      n.rdata = 32'h0000_0000;
      brk_start_now = 1'b0;
      tx_go = 1'b0;
      rx_done = 1'b0;
      rx_brk_hit = 1'b0;
      rx_frame_hit = 1'b0;
      rx_brk_end = 1'b0;

      // Register writes and reads; unmapped reads return zero
      if (wr_en) begin
         case (addr)
            uttb_pkg::OFF_MODE: begin
               n.mode_sync = wdata[uttb_pkg::MODE_SYNC];
               n.mode_par = wdata[uttb_pkg::MODE_PAR];
            end
            uttb_pkg::OFF_RXIDLE: n.to_value = wdata[15:0];
            uttb_pkg::OFF_GUARD: n.guard = wdata[7:0];
            uttb_pkg::OFF_BAUD: n.baud_div = wdata[15:0];
            default: ;
         endcase
      end
      if (rd_en) begin
         case (addr)
            uttb_pkg::OFF_MODE: n.rdata = {30'h0, s.mode_par, s.mode_sync};
            uttb_pkg::OFF_STATUS: n.rdata = status;
            uttb_pkg::OFF_RXIDLE: n.rdata = {16'h0000, s.to_value};
            uttb_pkg::OFF_GUARD: n.rdata = {24'h000000, s.guard};
            uttb_pkg::OFF_BAUD: n.rdata = {16'h0000, s.baud_div};
            default: n.rdata = 32'h0000_0000;
         endcase
      end

      // Holding register; a byte offered while a break waits is dropped
      if (hold_wr && !s.hold_full && !s.brk_pend) begin
         n.tx_hold = wdata[7:0];
         n.hold_full = 1'b1;
      end
      if (brk_start_ok) begin
         n.brk_pend = 1'b1;
      end
      if (brk_stop_ok) begin
         n.brk_stop_req = 1'b1;
      end

      // Transmit sequencer, stepped on bit ticks
      if (bit_tick) begin
         case (s.tx_state)
            uttb_pkg::TX_SHIFT: begin
               if (s.tx_bits != 4'h0) begin
                  n.txd = s.tx_shift[0];
                  n.tx_shift = {1'b1, s.tx_shift[9:1]};
                  n.tx_bits = s.tx_bits - 4'h1;
               end else if (s.guard != 8'h00) begin
                  n.tx_state = uttb_pkg::TX_GUARD;
                  n.tx_gcnt = s.guard;
               end else begin
                  tx_go = 1'b1;
               end
            end
            uttb_pkg::TX_GUARD: begin
               if (s.tx_gcnt == 8'h01) begin
                  tx_go = 1'b1;
               end else begin
                  n.tx_gcnt = s.tx_gcnt - 8'h01;
               end
            end
            uttb_pkg::TX_BREAK: begin
               // Minimum length runs out before a stop request is honoured
               if (s.tx_bits != 4'h0) begin
                  n.tx_bits = s.tx_bits - 4'h1;
               end else if (s.brk_stop_req) begin
                  n.tx_state = uttb_pkg::TX_POSTBRK;
                  n.txd = 1'b1;
                  n.tx_gcnt = post_len;
               end
            end
            uttb_pkg::TX_POSTBRK: begin
               if (s.tx_gcnt == 8'h01) begin
                  n.brk_on = 1'b0;
                  n.brk_stop_req = 1'b0;
                  tx_go = 1'b1;
               end else begin
                  n.tx_gcnt = s.tx_gcnt - 8'h01;
               end
            end
            default: tx_go = 1'b1;
         endcase
      end

      // Start next frame on the same tick so no idle bit slips in
      if (tx_go) begin
         n.tx_state = uttb_pkg::TX_IDLE;
         n.txd = 1'b1;
         if (s.hold_full) begin
            // A queued character goes first; the break follows it
            n.tx_state = uttb_pkg::TX_SHIFT;
            n.txd = 1'b0;
            n.tx_shift = {1'b1, s.mode_par ? ^s.tx_hold : 1'b1, s.tx_hold};
            n.tx_bits = uttb_pkg::TX_REM_BITS + {3'h0, s.mode_par};
            n.hold_full = 1'b0;
         end else if (s.brk_pend) begin
            n.tx_state = uttb_pkg::TX_BREAK;
            n.txd = 1'b0;
            n.tx_bits = uttb_pkg::TX_REM_BITS + {3'h0, s.mode_par};
            n.brk_pend = 1'b0;
            n.brk_on = 1'b1;
            brk_start_now = 1'b1;
         end
      end

      // Ready flags; break start drops both as a character would
      n.tx_free = !n.hold_full && !n.brk_pend && !brk_start_now;
      n.tx_all_idle = (n.tx_state == uttb_pkg::TX_IDLE) && !n.hold_full && !n.brk_pend;

      // Receive sequencer, stepped on sample ticks
      if (sample_tick) begin
         case (s.rx_state)
            uttb_pkg::RX_IDLE: begin
               if (!rxd) begin
                  n.rx_cnt = 4'h0;
                  n.rx_idx = 4'h0;
                  n.rx_zero = 1'b1;
                  n.rx_state = s.mode_sync ? uttb_pkg::RX_DATA : uttb_pkg::RX_START;
               end
            end
            uttb_pkg::RX_START: begin
               if (s.rx_cnt == rx_target) begin
                  n.rx_cnt = 4'h0;
                  n.rx_state = rxd ? uttb_pkg::RX_IDLE : uttb_pkg::RX_DATA;
               end else begin
                  n.rx_cnt = s.rx_cnt + 4'h1;
               end
            end
            uttb_pkg::RX_DATA: begin
               if (s.rx_cnt != rx_target) begin
                  n.rx_cnt = s.rx_cnt + 4'h1;
               end else if (s.rx_idx != rx_last) begin
                  n.rx_cnt = 4'h0;
                  n.rx_zero = s.rx_zero && !rxd;
                  n.rx_idx = s.rx_idx + 4'h1;
               end else begin
                  // Stop bit sampled at its middle
                  rx_done = 1'b1;
                  n.rx_state = uttb_pkg::RX_IDLE;
                  if (!rxd && s.rx_zero) begin
                     rx_brk_hit = 1'b1;
                     n.rx_state = uttb_pkg::RX_BREAK;
                     n.rx_hcnt = 2'h0;
                  end else if (!rxd) begin
                     rx_frame_hit = 1'b1;
                  end
               end
            end
            uttb_pkg::RX_BREAK: begin
               // Glitches shorter than the end length restart the count
               if (!rxd) begin
                  n.rx_hcnt = 2'h0;
               end else if ((s.rx_hcnt + 2'h1) == brk_end_need) begin
                  rx_brk_end = 1'b1;
                  n.rx_state = uttb_pkg::RX_IDLE;
               end else begin
                  n.rx_hcnt = s.rx_hcnt + 2'h1;
               end
            end
            default: n.rx_state = uttb_pkg::RX_IDLE;
         endcase
      end

      // Sticky receive flags; a new event wins over a clear
      if (clr_cmd) begin
         n.frame_flag = 1'b0;
         n.brk_flag = 1'b0;
      end
      if (rx_frame_hit) begin
         n.frame_flag = 1'b1;
      end
      if (rx_brk_hit || rx_brk_end) begin
         n.brk_flag = 1'b1;
      end

      // Idle time-out counter
      if (arm_cmd || reload_cmd) begin
         n.to_flag = 1'b0;
      end
      if (arm_cmd) begin
         n.to_run = 1'b0;
      end
      if (reload_cmd || rx_done) begin
         n.to_cnt = s.to_value;
         n.to_run = 1'b1;
      end else if (s.to_run && bit_tick && !arm_cmd) begin
         n.to_cnt = s.to_cnt - 16'h0001;
         if (s.to_cnt == 16'h0001) begin
            n.to_flag = 1'b1;
            n.to_run = 1'b0;
         end
      end
      // Zero value disables everything, whatever else happened
      if (s.to_value == 16'h0000) begin
         n.to_flag = 1'b0;
         n.to_run = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; counter waits for a first character after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.txd <= 1'b1;
         s.tx_free <= 1'b1;
         s.tx_all_idle <= 1'b1;
         s.baud_div <= uttb_pkg::BAUD_RST;
         s.to_value <= uttb_pkg::RXIDLE_RST;
         s.guard <= uttb_pkg::GUARD_RST;
      end else begin
         s <= n;
      end
   end

   assign rdata = s.rdata;
   assign txd = s.txd;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   to_zero_off_a: assert property ((s.to_value == 16'h0000) |=> !s.to_flag)
      else $error("time-out flag set with zero value");

   to_count_down_a: assert property (
      (s.to_run && bit_tick && s.to_cnt > 16'h0001 && !ctrl_wr && !rx_done
       && s.to_value != 16'h0000)
      |=> (s.to_cnt == $past(s.to_cnt) - 16'h0001) && s.to_run)
      else $error("time-out counter did not step down");

   to_fire_a: assert property (
      (s.to_run && bit_tick && s.to_cnt == 16'h0001 && !ctrl_wr && !rx_done
       && s.to_value != 16'h0000) |=> s.to_flag && !s.to_run)
      else $error("time-out flag not raised at zero");

   to_arm_stop_a: assert property (
      (arm_cmd && !reload_cmd && !rx_done) |=> !s.to_run
      ##1 (!s.to_run || $past(rx_done) || $past(reload_cmd)))
      else $error("counter ran while armed");

   to_reload_a: assert property (
      (reload_cmd && s.to_value != 16'h0000) |=> s.to_run && !s.to_flag
      && (s.to_cnt == $past(s.to_value)))
      else $error("reload did not restart counter");

   frame_set_a: assert property ((rx_frame_hit && !rx_brk_hit) |=> s.frame_flag)
      else $error("framing error not flagged");

   frame_hold_a: assert property ((s.frame_flag && !clr_cmd) |=> s.frame_flag)
      else $error("framing flag dropped without clear");

   break_hold_a: assert property ((s.brk_flag && !clr_cmd) |=> s.brk_flag)
      else $error("break flag dropped without clear");

   break_low_a: assert property (
      ($rose(s.tx_state == uttb_pkg::TX_BREAK)) |-> !s.txd
      && (s.tx_bits == uttb_pkg::TX_REM_BITS + {3'h0, s.mode_par}))
      else $error("break shorter than a character");

   break_ignore_a: assert property (
      (brk_start_cmd && s.brk_on) |=> !s.brk_pend)
      else $error("second break start taken");

   hold_drop_a: assert property ((hold_wr && s.brk_pend && !s.hold_full) |=> !s.hold_full)
      else $error("holding write taken during pending break");

   rx_break_a: assert property ((rx_brk_hit && !clr_cmd)
      |=> s.brk_flag && (s.frame_flag == $past(s.frame_flag)))
      else $error("receive break flagged wrongly");

   post_idle_a: assert property (
      ($rose(s.tx_state == uttb_pkg::TX_POSTBRK)) |-> s.txd
      && (s.tx_gcnt >= uttb_pkg::BRK_IDLE_MIN) && (s.tx_gcnt >= s.guard))
      else $error("post-break idle too short");

endmodule

// ---- bench/uttb_remote.sv ----
// Remote serial peer: drives the receive line, records run lengths on the transmit line
`timescale 1ns/1ps
module uttb_remote #(
   parameter int BIT = 32
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic txd,
   output logic rxd
);
   int runs[$];
   int cur;
   logic last;

   initial rxd = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // Each finished run of one level is logged in clock cycles
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur <= 0;
         last <= 1'b1;
      end else if (txd !== last) begin
         runs.push_back(cur);
         cur <= 1;
         last <= txd;
      end else begin
         cur <= cur + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One frame, LSB first; stop level and extra bits at stop level chosen by caller
   task automatic send(input logic [7:0] data, input logic stop, input int hold);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rxd <= data[i];
         repeat (BIT) @(posedge clk);
      end
      rxd <= stop;
      repeat (BIT * (1 + hold)) @(posedge clk);
      rxd <= 1'b1; // Idle high again, so an end of break is visible
   endtask
endmodule

// ---- bench/uttb_line_tb_top.sv ----
// Self-checking bench of the line-condition logic against a remote serial peer
`timescale 1ns/1ps
module uttb_line_tb_top;
   localparam int BIT = 32; // Divisor 1: sample every 2 clocks, 16 samples a bit
   localparam logic [4:0] M_BRK = 5'h04;
   localparam logic [4:0] M_FR = 5'h08;
   localparam logic [4:0] M_TO = 5'h10;
   typedef struct {logic [31:0] exp; logic [31:0] mask; string what;} uttb_note_s;
   logic clk, resetn, wr_en, rd_en, txd, rxd, rd_q;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   int n_errors = 0;
   int checks_done = 0;
   int seed = 32'h9F85;
   uttb_note_s notes[$];
   uttb_note_s nt;

   uttb_line i_uttb_line (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd(rxd), .txd(txd));
   uttb_remote #(.BIT(BIT)) i_uttb_remote (.clk(clk), .resetn(resetn), .txd(txd), .rxd(rxd));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Reader notes what it expects; the watcher below compares
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input string what);
      notes.push_back('{e, m, what});
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
   endtask

   task automatic st(input logic [4:0] e, input logic [4:0] m, input string what);
      rd(uttb_pkg::OFF_STATUS, {27'h0, e}, {27'h0, m}, what);
   endtask

   task automatic cmd(input int b);
      wr(uttb_pkg::OFF_CTRL, 32'h1 << b);
   endtask

   task automatic bits(input int n);
      repeat (n * BIT) @(posedge clk);
   endtask

   // Bounded wait for the peer to log n transmit-line runs
   task automatic wait_runs(input int n);
      for (int i = 0; i < 3000 && i_uttb_remote.runs.size() < n; i++) @(posedge clk);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Read data stands only the cycle after the strobe, so look exactly there
   always @(posedge clk) begin
      rd_q <= rd_en;
      if (rd_q) begin
         nt = notes.pop_front();
         chk(nt.what, nt.exp & nt.mask, rdata & nt.mask);
      end
   end

   // Watchdog, well above the few thousand cycles the tests need
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      st(5'h03, 5'h1F, "status after reset");
      rd(uttb_pkg::OFF_RXIDLE, 32'h0, 32'hFFFFFFFF, "time-out value after reset");
      rd(8'h3C, 32'h0, 32'hFFFFFFFF, "unmapped read");
      wr(uttb_pkg::OFF_BAUD, 32'h1);
      $display("test reset done");
      // Zero value never times out, even with a reload
      i_uttb_remote.send(8'($random(seed)), 1'b1, 0);
      cmd(uttb_pkg::CMD_RELOAD);
      bits(20);
      st(5'h00, M_TO, "timeout with zero value");
      $display("test zero time-out done");
      // Counter of 3 bits: loaded by a character, rearmed, reloaded
      wr(uttb_pkg::OFF_RXIDLE, 32'h3);
      i_uttb_remote.send(8'($random(seed)), 1'b1, 0);
      bits(1);
      st(5'h00, M_TO, "timeout early after char");
      bits(4);
      st(M_TO, M_TO, "timeout after char");
      // Counter left running so that the arm really has to stop it
      cmd(uttb_pkg::CMD_RELOAD);
      st(5'h00, M_TO, "timeout cleared by reload");
      cmd(uttb_pkg::CMD_ARM);
      st(5'h00, M_TO, "timeout after arm");
      bits(6);
      st(5'h00, M_TO, "timeout while armed idle");
      cmd(uttb_pkg::CMD_RELOAD);
      st(5'h00, M_TO, "timeout after reload");
      bits(1);
      st(5'h00, M_TO, "timeout early after reload");
      bits(4);
      st(M_TO, M_TO, "timeout after reload");
      cmd(uttb_pkg::CMD_ARM);
      st(5'h00, M_TO, "timeout cleared by arm");
      wr(uttb_pkg::OFF_RXIDLE, 32'h0);
      $display("test time-out done");
      // Low stop bit on a nonzero character
      i_uttb_remote.send(8'($random(seed)) | 8'h01, 1'b0, 0);
      bits(1);
      st(M_FR, M_FR | M_BRK, "framing after low stop");
      bits(3);
      st(M_FR, M_FR, "framing held");
      cmd(uttb_pkg::CMD_CLR);
      st(5'h00, M_FR, "framing cleared");
      $display("test framing done");
      // All-zero frame held low, cleared mid-break, then released
      fork
         i_uttb_remote.send(8'h00, 1'b0, 4);
         begin
            bits(10);
            st(M_BRK, M_BRK | M_FR, "break on zero frame");
            cmd(uttb_pkg::CMD_CLR);
            st(5'h00, M_BRK, "break cleared");
         end
      join
      bits(1);
      st(M_BRK, M_BRK, "break end flagged");
      cmd(uttb_pkg::CMD_CLR);
      $display("test receive break done");
      // Parity on: zero data with low parity and stop bits is still a break
      wr(uttb_pkg::OFF_MODE, 32'h2);
      rd(uttb_pkg::OFF_MODE, 32'h2, 32'hFFFFFFFF, "mode readback");
      i_uttb_remote.send(8'h00, 1'b0, 1);
      bits(1);
      st(M_BRK, M_BRK | M_FR, "break with parity");
      cmd(uttb_pkg::CMD_CLR);
      wr(uttb_pkg::OFF_MODE, 32'h0);
      $display("test parity break done");
      // Stop without start leaves the line idle
      i_uttb_remote.runs.delete();
      cmd(uttb_pkg::CMD_BRK_STOP);
      bits(15);
      chk("runs after lone stop", 32'h0, i_uttb_remote.runs.size());
      $display("test lone stop done");
      // Break behind a character, with a byte discarded and an early stop
      wr(uttb_pkg::OFF_GUARD, 32'hE);
      wr(uttb_pkg::OFF_TXHOLD, 32'hFF);
      bits(1);
      cmd(uttb_pkg::CMD_BRK_START); // Never together with stop
      cmd(uttb_pkg::CMD_BRK_START);
      wr(uttb_pkg::OFF_TXHOLD, 32'h00);
      st(5'h00, 5'h03, "ready flags while break waits");
      // Stop is taken only once the break is on the line; it is still early
      wait_runs(3);
      st(5'h01, 5'h03, "ready flags during break");
      cmd(uttb_pkg::CMD_BRK_START);
      cmd(uttb_pkg::CMD_BRK_STOP);
      wait_runs(4);
      bits(1);
      wr(uttb_pkg::OFF_TXHOLD, 32'h00);
      wait_runs(6);
      bits(2);
      chk("run count", 32'h6, i_uttb_remote.runs.size());
      chk("start bit before break", BIT, i_uttb_remote.runs[1]);
      chk("char and guard before break", 23 * BIT, i_uttb_remote.runs[2]);
      chk("break length", 32'h1, {31'h0, i_uttb_remote.runs[3] >= 10 * BIT});
      chk("idle after break", 32'h1, {31'h0, i_uttb_remote.runs[4] >= 14 * BIT});
      chk("next char low run", 9 * BIT, i_uttb_remote.runs[5]);
      $display("test transmit break done");
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule
